// >>> design/brk_cmp_pkg.sv
// Purpose: Shared constants and types for the breakpoint comparators.
// Assumes: Byte-wide register port, one CPU bus clock.
// Notes: All offsets are byte addresses on the register port.
package brk_cmp_pkg;

  // Register offsets
  localparam logic [7:0] OFS_CTL_ONE = 8'h20;
  localparam logic [7:0] OFS_CTL_TWO = 8'h21;
  localparam logic [7:0] OFS_CTL_THREE = 8'h22;
  localparam logic [7:0] OFS_STATUS = 8'h26;
  localparam logic [7:0] OFS_C_EXT = 8'h27;
  localparam logic [7:0] OFS_C_HIGH = 8'h28;
  localparam logic [7:0] OFS_C_LOW = 8'h29;
  localparam logic [7:0] OFS_A_EXT = 8'h2a;
  localparam logic [7:0] OFS_A_HIGH = 8'h2b;
  localparam logic [7:0] OFS_A_LOW = 8'h2c;
  localparam logic [7:0] OFS_B_EXT = 8'h2d;
  localparam logic [7:0] OFS_B_HIGH = 8'h2e;
  localparam logic [7:0] OFS_B_LOW = 8'h2f;

  // Reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;

  // Control one fields
  localparam int TRACE_EN_BIT = 7;
  // Control two fields
  localparam int C_ENABLE_BIT = 7;
  localparam int C_TAG_BIT = 6;
  localparam int C_RW_EN_BIT = 5;
  localparam int C_RW_VAL_BIT = 4;
  localparam int ACTION_BIT = 3;
  localparam int FULL_MODE_BIT = 2;
  localparam int TAG_AB_BIT = 1;
  localparam int BKP_EN_BIT = 0;
  localparam logic [3:0] C_ALL_SET = 4'hf;
  // Control three fields
  localparam int MASK_A_HIGH_BIT = 7;
  localparam int MASK_A_LOW_BIT = 6;
  localparam int MASK_B_HIGH_BIT = 5;
  localparam int MASK_B_LOW_BIT = 4;
  localparam int RW_EN_A_BIT = 3;
  localparam int RW_VAL_A_BIT = 2;
  localparam int RW_EN_B_BIT = 1;
  localparam int RW_VAL_B_BIT = 0;
  // Extended register fields
  localparam int PAGE_SEL_LOW_BIT = 6;

  // CPU core bus sampled each clock
  typedef struct packed {
    logic valid;          // Bus cycle in progress
    logic read;           // 1 read, 0 write
    logic prog_page;      // Program flash or ROM access
    logic opcode_fetch;   // Cycle fetches an opcode
    logic [21:14] xaddr;  // Extended address bus
    logic [15:0] addr;    // Core address bus
    logic [15:0] data;    // Core data bus
  } cpu_bus_type;

endpackage

// >>> design/brk_cmp.sv
// Purpose: Breakpoint comparators A, B and C of the on-chip debug unit.
// Assumes: CPU bus, boundary and execute strobes are on CLK already.
// Notes: Requests are one-cycle pulses to the background debug logic.
`timescale 1ns/1ps

module brk_cmp
  import brk_cmp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire cpu_bus_type CPU_BUS,
  input wire logic INSTR_BOUNDARY,
  input wire logic TAG_EXEC,
  input wire logic SECURE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic BGND_REQ,
  output logic SWI_REQ,
  output logic MATCH_A,
  output logic MATCH_B,
  output logic BKP_MODE,
  output logic TRACE_MODE
);

  // Whole state of the block
  typedef struct packed {
    logic [7:0] ctl_one;     // Trace enable
    logic [7:0] ctl_two;     // Mode, action, tag, comparator C
    logic [7:0] ctl_three;   // Masks and cycle type
    logic [7:0] a_ext;       // Comparator A page and extended bits
    logic [7:0] a_high;
    logic [7:0] a_low;
    logic [7:0] b_ext;       // Comparator B page and extended bits
    logic [7:0] b_high;
    logic [7:0] b_low;
    logic [7:0] c_ext;       // Comparator C
    logic [7:0] c_high;
    logic [7:0] c_low;
    logic forced_pend;       // Forced break waiting for boundary
    logic tag_pend;          // Tagged opcode waiting to execute
    logic [7:0] rdata;       // Read answer
    logic bgnd_req;
    logic swi_req;
    logic match_a;
    logic match_b;
    logic bkp_mode;
    logic trace_mode;
  } state_type;

  state_type s;       // Registered state
  state_type next_s;  // Next state

  // Decoded modes and compare results
  logic breakpoint_mode;          // Breakpoint mode active
  logic trace;        // Trace mode active
  logic full;         // Full breakpoint sub-mode
  logic tag_ab;       // A and B give tagged breaks
  logic c_on;         // Comparator C enabled
  logic addr_a;       // A address compare
  logic addr_b;       // B address compare
  logic addr_c;       // C address compare
  logic data_ok;      // B data compare
  logic rw_a;         // A cycle type allowed
  logic rw_b;         // B cycle type allowed
  logic rw_c;         // C cycle type allowed
  logic hit_forced;   // Forced break condition this cycle
  logic tag_hit;      // Tagged opcode seen this cycle
  logic issue;        // Request goes out next cycle

  // One address compare against ext/high/low
  function automatic logic addr_cmp(input logic [7:0] ext,
                                    input logic [7:0] high,
                                    input logic [7:0] low,
                                    input logic trace_on,
                                    input logic mask_h,
                                    input logic mask_l,
                                    input cpu_bus_type b);
    logic ext_ok;
    logic hi_ok;
    logic lo_ok;
    logic ign_lo;
    logic ign_hi;
    ext_ok = 1'b1;
    // Selector bit 7 is never looked at, so 10/11 act as 00/01
    if (trace_on) begin
      if (ext[PAGE_SEL_LOW_BIT]) begin
        ext_ok = (ext[5:0] == b.xaddr[21:16]);
        hi_ok = (high == {b.xaddr[15:14], b.addr[13:8]});
      end else begin
        hi_ok = (high == b.addr[15:8]);
      end
    end else if (b.prog_page) begin
      ext_ok = (ext[5:0] == b.xaddr[19:14]);
      hi_ok = (high[5:0] == b.addr[13:8]);
    end else begin
      hi_ok = (high == b.addr[15:8]);
    end
    lo_ok = (low == b.addr[7:0]);
    // Mask 1:0 has no sensible meaning and stays a full compare
    ign_lo = mask_l;
    ign_hi = mask_h & mask_l;
    return ext_ok & (ign_hi | hi_ok) & (ign_lo | lo_ok);
  endfunction

  // Mode decode and comparators
  always_comb begin
    breakpoint_mode = s.ctl_two[BKP_EN_BIT];
    trace = s.ctl_one[TRACE_EN_BIT] & ~breakpoint_mode & ~SECURE;
    full = s.ctl_two[FULL_MODE_BIT];
    tag_ab = s.ctl_two[TAG_AB_BIT];
    c_on = breakpoint_mode & (s.ctl_two[7:4] == C_ALL_SET);
    // Masks only shape compares in breakpoint mode
    addr_a = addr_cmp(s.a_ext, s.a_high, s.a_low, trace,
                      breakpoint_mode & s.ctl_three[MASK_A_HIGH_BIT],
                      breakpoint_mode & s.ctl_three[MASK_A_LOW_BIT], CPU_BUS);
    addr_b = addr_cmp(s.b_ext, s.b_high, s.b_low, trace,
                      breakpoint_mode & s.ctl_three[MASK_B_HIGH_BIT],
                      breakpoint_mode & s.ctl_three[MASK_B_LOW_BIT], CPU_BUS);
    addr_c = addr_cmp(s.c_ext, s.c_high, s.c_low, 1'b0, 1'b0, 1'b0,
                      CPU_BUS);
    // Data masks: high bit drops high byte, low bit drops low byte
    data_ok = (s.ctl_three[MASK_B_HIGH_BIT] |
               (s.b_high == CPU_BUS.data[15:8])) &
              (s.ctl_three[MASK_B_LOW_BIT] |
               (s.b_low == CPU_BUS.data[7:0]));
    // Value bit 1 picks reads, 0 picks writes
    rw_a = ~s.ctl_three[RW_EN_A_BIT] |
           (s.ctl_three[RW_VAL_A_BIT] == CPU_BUS.read);
    rw_b = ~s.ctl_three[RW_EN_B_BIT] |
           (s.ctl_three[RW_VAL_B_BIT] == CPU_BUS.read);
    rw_c = ~s.ctl_two[C_RW_EN_BIT] |
           (s.ctl_two[C_RW_VAL_BIT] == CPU_BUS.read);
    hit_forced = 1'b0;
    tag_hit = 1'b0;
    if (breakpoint_mode && CPU_BUS.valid) begin
      if (full) begin
        // B cycle type bits play no part here
        hit_forced = ~tag_ab & addr_a & rw_a & data_ok;
        tag_hit = tag_ab & CPU_BUS.opcode_fetch & addr_a;
      end else begin
        // Two address breaks, data never consulted
        hit_forced = ~tag_ab &
                     ((addr_a & rw_a) | (addr_b & rw_b));
        tag_hit = tag_ab & CPU_BUS.opcode_fetch &
                  (addr_a | addr_b);
      end
      // Comparator C always tags; cycle type is read on opcodes
      if (c_on && CPU_BUS.opcode_fetch && addr_c && rw_c) begin
        tag_hit = 1'b1;
      end
    end
    issue = (s.forced_pend & INSTR_BOUNDARY) |
            (s.tag_pend & TAG_EXEC);
  end

  // Next state: registers, pending breaks, requests
  always_comb begin
    next_s = s;
    next_s.rdata = REG_RESET;
    next_s.bgnd_req = 1'b0;
    next_s.swi_req = 1'b0;
    // A new match in the issuing cycle stays pending
    next_s.forced_pend = (s.forced_pend & ~INSTR_BOUNDARY) |
                         hit_forced;
    next_s.tag_pend = (s.tag_pend & ~TAG_EXEC) | tag_hit;
    // Leaving breakpoint mode drops anything still waiting
    if (!breakpoint_mode) begin
      next_s.forced_pend = 1'b0;
      next_s.tag_pend = 1'b0;
    end
    // One action bit, so only one request can ever fire
    if (issue) begin
      if (s.ctl_two[ACTION_BIT]) begin
        next_s.bgnd_req = 1'b1;
      end else begin
        next_s.swi_req = 1'b1;
      end
    end
    // Raw matches for the trace controller
    next_s.match_a = CPU_BUS.valid & (breakpoint_mode | trace) & addr_a;
    next_s.match_b = CPU_BUS.valid & (breakpoint_mode | trace) &
                     ((breakpoint_mode & full) ? data_ok : addr_b);
    next_s.bkp_mode = breakpoint_mode;
    next_s.trace_mode = trace;
    // Register writes
    if (REG_WR) begin
      unique case (REG_ADDR)
        OFS_CTL_ONE: begin
          // Trace enable cannot be set while secured
          next_s.ctl_one = REG_WDATA;
          next_s.ctl_one[TRACE_EN_BIT] =
            REG_WDATA[TRACE_EN_BIT] & ~SECURE;
        end
        OFS_CTL_TWO: next_s.ctl_two = REG_WDATA;
        OFS_CTL_THREE: next_s.ctl_three = REG_WDATA;
        OFS_A_EXT: next_s.a_ext = REG_WDATA;
        OFS_A_HIGH: next_s.a_high = REG_WDATA;
        OFS_A_LOW: next_s.a_low = REG_WDATA;
        OFS_B_EXT: next_s.b_ext = REG_WDATA;
        OFS_B_HIGH: next_s.b_high = REG_WDATA;
        OFS_B_LOW: next_s.b_low = REG_WDATA;
        OFS_C_EXT: next_s.c_ext = REG_WDATA;
        OFS_C_HIGH: next_s.c_high = REG_WDATA;
        OFS_C_LOW: next_s.c_low = REG_WDATA;
        // Status and unmapped writes are dropped
        default: next_s.rdata = REG_RESET;
      endcase
    end
    // Register reads, answer the next cycle
    if (REG_RD) begin
      unique case (REG_ADDR)
        OFS_CTL_ONE: next_s.rdata = s.ctl_one;
        OFS_CTL_TWO: next_s.rdata = s.ctl_two;
        OFS_CTL_THREE: next_s.rdata = s.ctl_three;
        OFS_STATUS: next_s.rdata = {4'h0, s.tag_pend, s.forced_pend,
                                    trace, breakpoint_mode};
        OFS_A_EXT: next_s.rdata = s.a_ext;
        OFS_A_HIGH: next_s.rdata = s.a_high;
        OFS_A_LOW: next_s.rdata = s.a_low;
        OFS_B_EXT: next_s.rdata = s.b_ext;
        OFS_B_HIGH: next_s.rdata = s.b_high;
        OFS_B_LOW: next_s.rdata = s.b_low;
        OFS_C_EXT: next_s.rdata = s.c_ext;
        OFS_C_HIGH: next_s.rdata = s.c_high;
        OFS_C_LOW: next_s.rdata = s.c_low;
        // Unmapped reads answer zero
        default: next_s.rdata = REG_RESET;
      endcase
    end
  end

  // State register, everything clears on reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign REG_RDATA = s.rdata;
  assign BGND_REQ = s.bgnd_req;
  assign SWI_REQ = s.swi_req;
  assign MATCH_A = s.match_a;
  assign MATCH_B = s.match_b;
  assign BKP_MODE = s.bkp_mode;
  assign TRACE_MODE = s.trace_mode;

  // Checks on the block's own behaviour
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_req_exclusive: assert property (!(BGND_REQ && SWI_REQ))
    else $error("Both requests raised together");

  a_action_select: assert property (
    BGND_REQ |-> $past(s.ctl_two[ACTION_BIT]))
    else $error("Debug request without action bit");

  a_forced_boundary: assert property (
    (s.forced_pend && INSTR_BOUNDARY) |=> (BGND_REQ || SWI_REQ))
    else $error("Forced break missed the boundary");

  a_tag_exec: assert property (
    (BGND_REQ || SWI_REQ) |->
      $past(s.forced_pend && INSTR_BOUNDARY) ||
      $past(s.tag_pend && TAG_EXEC))
    else $error("Request without pending break");

  a_secure_trace: assert property ($past(SECURE) |-> !TRACE_MODE)
    else $error("Trace mode while secured");

  a_bkp_blocks: assert property (BKP_MODE |-> !TRACE_MODE)
    else $error("Trace mode beside breakpoint mode");

  a_full_and: assert property (
    (breakpoint_mode && full && hit_forced) |-> (addr_a && data_ok))
    else $error("Full break without address and data");

  a_tag_nodata: assert property (
    (breakpoint_mode && full && tag_ab && CPU_BUS.valid &&
     CPU_BUS.opcode_fetch && addr_a) |=> s.tag_pend)
    else $error("Full tagged break waited on data");

  a_rw_select: assert property (
    (breakpoint_mode && !full && hit_forced && !(addr_b && rw_b)) |->
      (!s.ctl_three[RW_EN_A_BIT] ||
       s.ctl_three[RW_VAL_A_BIT] == CPU_BUS.read))
    else $error("Wrong cycle type matched");

  a_reg_readback: assert property (
    (REG_WR && REG_ADDR == OFS_A_LOW) ##1
    (REG_RD && REG_ADDR == OFS_A_LOW && !REG_WR) |=>
      REG_RDATA == $past(REG_WDATA, 2))
    else $error("Comparator register read back wrong");

  c_bgnd: cover property (BGND_REQ);
  c_swi: cover property (SWI_REQ);
  c_tagged: cover property (s.tag_pend && TAG_EXEC);
  c_trace_match: cover property (TRACE_MODE && MATCH_A);

endmodule

// >>> verif/cpu_side_model.sv
// Purpose: CPU core side model that drives the bus cycles.
// Assumes: The bench asks for one bus cycle at a time through GO.
// Notes: The idle bus shows the inverse of its last value, not a copy.
`timescale 1ns/1ps
module cpu_side_model
  import brk_cmp_pkg::*;
(
  input wire logic CLK,
  input wire logic GO,
  input wire cpu_bus_type CMD,
  output cpu_bus_type CPU_BUS
);
  // Last bus value, so that the idle pattern moves every cycle
  cpu_bus_type last = '0;
  // Command while asked, else a changing pattern with no cycle
  always_comb begin
    CPU_BUS = GO ? CMD : ~last;
    if (!GO) begin
      CPU_BUS.valid = 1'b0; // Idle bus carries no valid cycle
    end
  end
  // Remember what the bus showed
  always_ff @(posedge CLK) begin
    last <= CPU_BUS;
  end
endmodule

// >>> verif/tb_breakpoint_address_comparators.sv
// Purpose: Self-checking bench for the breakpoint comparators.
// Assumes: Design outputs settle before the falling clock edge.
// Notes: Random configurations with a fixed seed, plus corner tables.
`timescale 1ns/1ps
module tb_breakpoint_address_comparators
  import brk_cmp_pkg::*;
;
  logic clk, rst, go, bnd, tag, sec, wr, rd;
  logic [7:0] addr, wdata, rdata, d, c3;
  logic bgnd, software_interrupt, ma, mb, bkpm, trm, tr, ea;
  logic [7:0] v[3]; // Random A register values
  cpu_bus_type cmd, bus, b;
  int fail_count, total_checks, cycles;
  // Full mode table: ctl three, data, tagged, request expected
  logic [7:0] fc[7] = '{8'h00, 8'h00, 8'h10, 8'h20, 8'h30, 8'h0c, 8'h03};
  logic [15:0] fd[7] = '{16'hbeef, 16'hbe00, 16'hbe00, 16'h00ef,
                         16'h0000, 16'hbeef, 16'hbeef};
  logic [6:0] ftg = 7'b0000001; // Only case 0 is tagged, data mismatch
  logic [6:0] fx = 7'b1011101; // Bit j gives the request of case j
  cpu_side_model u_cpu (.CLK(clk), .GO(go), .CMD(cmd), .CPU_BUS(bus));
  brk_cmp u_dut (.CLK(clk), .RST(rst), .CPU_BUS(bus),
    .INSTR_BOUNDARY(bnd), .TAG_EXEC(tag), .SECURE(sec),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .BGND_REQ(bgnd), .SWI_REQ(software_interrupt), .MATCH_A(ma),
    .MATCH_B(mb), .BKP_MODE(bkpm), .TRACE_MODE(trm));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Compare and count
  task automatic check(string n, logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One write strobe cycle
  task automatic wr_reg(logic [7:0] a, logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Write then read back with no gap between the two strobes
  task automatic wr_rd(logic [7:0] a, logic [7:0] x,
                       output logic [7:0] y);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    y = rdata;
  endtask
  // Read strobe, data taken in the one cycle after it
  task automatic rd_reg(logic [7:0] a, output logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    x = rdata;
  endtask
  // One bus cycle, returns once MATCH outputs are settled
  task automatic cyc(cpu_bus_type c);
    @(posedge clk);
    cmd <= c;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
  endtask
  // Boundary or tag execute strobe, returns in the request cycle
  task automatic pulse(logic t);
    @(posedge clk);
    if (t) tag <= 1'b1;
    else bnd <= 1'b1;
    @(posedge clk);
    tag <= 1'b0;
    bnd <= 1'b0;
    @(negedge clk);
  endtask
  // Expected comparator A match from registers and bus
  function automatic logic exp_a(logic [7:0] x, h, l, m, logic t,
                                 cpu_bus_type c);
    logic e, hi, lo;
    if (t && x[PAGE_SEL_LOW_BIT]) begin
      e = x[5:0] == c.xaddr[21:16];
      hi = h == {c.xaddr[15:14], c.addr[13:8]};
    end else if (!t && c.prog_page) begin
      e = x[5:0] == c.xaddr[19:14];
      hi = h[5:0] == c.addr[13:8];
    end else begin
      e = 1'b1;
      hi = h == c.addr[15:8];
    end
    lo = l == c.addr[7:0];
    if (!t && m[MASK_A_LOW_BIT]) begin
      lo = 1'b1;
      hi = hi | m[MASK_A_HIGH_BIT];
    end
    // Raw match output carries no cycle type qualification
    return c.valid && e && hi && lo;
  endfunction
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      results();
    end
  end
  // Main sequence
  initial begin
    {rst, go, bnd, tag, sec, wr, rd} = 7'h40;
    {addr, wdata} = '0;
    cmd = '0;
    void'($urandom(90));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Reset values and read back of comparator A and B registers
    for (int k = 0; k < 6; k++) begin
      rd_reg(OFS_A_EXT + k[7:0], d);
      check("reset", d, REG_RESET);
      c3 = 8'($urandom);
      wr_rd(OFS_A_EXT + k[7:0], c3, d);
      check("readback", d, c3);
    end
    rd_reg(8'h30, d);
    check("unmapped", d, 8'h00);
    // Secure chip blocks trace, breakpoint enable wins
    @(posedge clk);
    sec <= 1'b1;
    wr_reg(OFS_CTL_ONE, 8'h80);
    rd_reg(OFS_CTL_ONE, d);
    check("trace_bit", d, 8'h00);
    check("trace_mode", trm, 1'b0);
    @(posedge clk);
    sec <= 1'b0;
    wr_reg(OFS_CTL_ONE, 8'h80);
    repeat (2) @(negedge clk);
    check("trace_on", trm, 1'b1);
    // Securing the chip with the enable already set stops trace
    @(posedge clk);
    sec <= 1'b1;
    repeat (2) @(negedge clk);
    check("trace_secured", trm, 1'b0);
    @(posedge clk);
    sec <= 1'b0;
    wr_reg(OFS_CTL_TWO, 8'h01);
    repeat (2) @(negedge clk);
    check("bkp_wins", {bkpm, trm}, 2'b10);
    // Random paging, masks and cycle types on comparator A
    for (int i = 0; i < 60; i++) begin
      tr = $urandom % 2;
      for (int k = 0; k < 3; k++) v[k] = $urandom;
      // B masks stay clear so that comparator B never matches here
      c3 = tr ? 8'h00 : (8'($urandom) & 8'hcf);
      wr_reg(OFS_CTL_TWO, 8'h00);
      wr_reg(OFS_CTL_TWO, {7'h0, !tr});
      wr_reg(OFS_B_HIGH, ~v[1]);
      wr_reg(OFS_CTL_ONE, {tr, 7'h0});
      wr_reg(OFS_CTL_THREE, c3);
      for (int k = 0; k < 3; k++) wr_reg(OFS_A_EXT + k[7:0], v[k]);
      b = cpu_bus_type'({$urandom, $urandom});
      b.valid = 1'b1;
      b.addr = {v[1], v[2]};
      if (tr) b.xaddr = {v[0][5:0], v[1][7:6]};
      else b.xaddr[19:14] = v[0][5:0];
      if ($urandom % 2) b.addr[$urandom % 16] ^= 1'b1;
      cyc(b);
      ea = exp_a(v[0], v[1], v[2], c3, tr, b);
      check("match_a", ma, ea);
      // Forced break waits pending only for an allowed cycle type
      rd_reg(OFS_STATUS, d);
      ea = !tr && ea && (!c3[RW_EN_A_BIT] || b.read == c3[RW_VAL_A_BIT]);
      check("pend_a", d[2], ea);
    end
    // Dual mode requests: action and tag select
    wr_reg(OFS_CTL_ONE, 8'h00);
    wr_reg(OFS_A_EXT, 8'h00);
    wr_reg(OFS_A_HIGH, 8'h12);
    wr_reg(OFS_A_LOW, 8'h34);
    b = '0;
    b.valid = 1'b1;
    b.read = 1'b1;
    b.opcode_fetch = 1'b1;
    b.addr = 16'h1234;
    for (int j = 0; j < 4; j++) begin
      wr_reg(OFS_CTL_TWO, 8'h00);
      wr_reg(OFS_CTL_THREE, 8'h00);
      wr_reg(OFS_CTL_TWO, {4'h0, j[0], 1'b0, j[1], 1'b1});
      b.data = $urandom;
      cyc(b);
      check("early_req", {bgnd, software_interrupt}, 2'b00);
      pulse(j[1]);
      check("req", {bgnd, software_interrupt}, {j[0], !j[0]});
      @(negedge clk);
      check("req_end", {bgnd, software_interrupt}, 2'b00);
    end
    // Full mode: address and data, data masks, cycle type
    wr_reg(OFS_B_HIGH, 8'hbe);
    wr_reg(OFS_B_LOW, 8'hef);
    for (int j = 0; j < 7; j++) begin
      wr_reg(OFS_CTL_TWO, 8'h00);
      wr_reg(OFS_CTL_THREE, fc[j]);
      wr_reg(OFS_CTL_TWO, ftg[j] ? 8'h0f : 8'h0d);
      b.read = ftg[j];
      b.data = ftg[j] ? 16'h0000 : fd[j];
      cyc(b);
      if (j < 5 && j > 0) check("match_b", mb, fx[j]);
      pulse(ftg[j]);
      check("full_req", bgnd, fx[j]);
    end
    results();
  end
endmodule
